// ==== tpsro_regs.sv ====
// TPS capture and readout registers with freeze-for-read and soft reset.
// Assumes live TPS data and lock flags on clk_sys, and a host on the
// two-wire serial bus that drives its pins from another clock.
`timescale 1ns/100ps
module tpsro_regs
#(
    parameter logic [2:0] ADDR_HI = 3'b010 // Fixed upper slave address bits
)
(
    input wire logic clk_sys, // System clock, 125 MHz
    input wire logic nrst, // Synchronous reset, active low
    input wire logic [3:0] bus_id, // Board strap, low address bits
    input wire logic scl_in, // Serial clock pin
    input wire logic sda_in, // Serial data pin, level seen
    output logic sda_out, // Serial data pin, driven level
    output logic sda_oe, // Serial data pin, drive enable
    input wire logic [67:0] tps_word, // Decoded parameter word
    input wire logic tps_word_valid, // New decoded word, one cycle
    input wire tpsro_pkg::tpsro_lock_s lock_flags, // Live lock flags
    output logic soft_rst_pulse, // Restart loops, one cycle
    output logic tps_frozen // Refreshing suspended
);
    import tpsro_pkg::*;

    if (ADDR_HI == 3'b000)
    begin : g_addr_check
        $error("ADDR_HI zero collides with reserved bus addresses");
    end

    function automatic logic [7:0] tps_byte(input logic [71:0] w,
        input logic [7:0] idx);
        logic [6:0] base;
        base = {idx[3:0], 3'b000};
        if (idx < {4'h0, TPSRO_NUM_BYTES})
            tps_byte = w[base +: 8];
        else
            tps_byte = 8'h00;
    endfunction : tps_byte

    logic sda_lvl, scl_rise, scl_fall, bus_start, bus_stop;

    tpsro_pin_sync u_sync
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_lvl(sda_lvl),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .bus_start(bus_start),
        .bus_stop(bus_stop)
    );

    // ------------------------------------------------------------------
    // Serial slave
    // ------------------------------------------------------------------
    tpsro_i2c_e ist_reg, ist_next;
    logic [7:0] sh_reg, sh_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] ptr_reg, ptr_next;
    logic [7:0] rd_addr_reg, rd_addr_next;
    logic rw_reg, rw_next;
    logic first_reg, first_next;
    logic oe_reg, oe_next;
    logic [3:0] id_meta_reg, id_reg;
    logic wr_stb;
    logic [7:0] wr_addr, wr_data;
    logic rd_done;
    logic [7:0] rd_byte;

    logic [71:0] snap_reg, snap_next;
    logic [3:0] pend_reg, pend_next;
    logic frz_reg, frz_next;

    always_comb
    begin
        ist_next = ist_reg;
        sh_next = sh_reg;
        cnt_next = cnt_reg;
        ptr_next = ptr_reg;
        rd_addr_next = rd_addr_reg;
        rw_next = rw_reg;
        first_next = first_reg;
        oe_next = oe_reg;
        wr_stb = 1'b0;
        wr_addr = ptr_reg;
        wr_data = sh_reg;
        rd_done = 1'b0;
        rd_byte = tps_byte(snap_reg, ptr_reg);
        if (bus_start)
        begin
            ist_next = TPSRO_I_ADDR;
            cnt_next = TPSRO_BITCNT_RST;
            first_next = 1'b1;
            oe_next = 1'b0;
        end
        else if (bus_stop)
        begin
            ist_next = TPSRO_I_IDLE;
            oe_next = 1'b0;
        end
        else
        begin
            case (ist_reg)
                TPSRO_I_ADDR, TPSRO_I_WR:
                begin
                    if (scl_rise)
                    begin
                        sh_next = {sh_reg[6:0], sda_lvl};
                        cnt_next = cnt_reg + 4'h1;
                    end
                    else if (scl_fall && cnt_reg == TPSRO_BYTE_BITS)
                    begin
                        if (ist_reg == TPSRO_I_ADDR)
                        begin
                            if (sh_reg[7:1] == {ADDR_HI, id_reg})
                            begin
                                oe_next = 1'b1;
                                rw_next = sh_reg[0];
                                ist_next = TPSRO_I_ACK_A;
                            end
                            else
                                ist_next = TPSRO_I_IDLE;
                        end
                        else
                        begin
                            // First data byte sets the pointer
                            oe_next = 1'b1;
                            ist_next = TPSRO_I_ACK_W;
                            first_next = 1'b0;
                            if (first_reg)
                                ptr_next = sh_reg;
                            else
                            begin
                                wr_stb = 1'b1;
                                ptr_next = ptr_reg + 8'h01;
                            end
                        end
                    end
                end
                TPSRO_I_ACK_A, TPSRO_I_ACK_W:
                begin
                    if (scl_fall)
                    begin
                        cnt_next = TPSRO_BITCNT_RST;
                        if (rw_reg)
                        begin
                            sh_next = rd_byte;
                            oe_next = ~rd_byte[7];
                            rd_addr_next = ptr_reg;
                            ptr_next = ptr_reg + 8'h01;
                            ist_next = TPSRO_I_RD;
                        end
                        else
                        begin
                            oe_next = 1'b0;
                            ist_next = TPSRO_I_WR;
                        end
                    end
                end
                TPSRO_I_RD:
                begin
                    if (scl_rise)
                    begin
                        cnt_next = cnt_reg + 4'h1;
                        sh_next = {sh_reg[6:0], 1'b0};
                    end
                    else if (scl_fall)
                    begin
                        if (cnt_reg == TPSRO_BYTE_BITS)
                        begin
                            oe_next = 1'b0;
                            ist_next = TPSRO_I_ACK_R;
                        end
                        else
                            oe_next = ~sh_reg[7];
                    end
                end
                TPSRO_I_ACK_R:
                begin
                    if (scl_rise)
                    begin
                        // Byte counts as read when the clock rises in its acknowledge slot
                        rd_done = rd_addr_reg <= TPSRO_OFS_DATA_8;
                        if (sda_lvl)
                            ist_next = TPSRO_I_IDLE;
                        else
                            ist_next = TPSRO_I_ACK_A;
                    end
                end
                default:
                    ist_next = TPSRO_I_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            ist_reg <= TPSRO_I_IDLE;
            sh_reg <= 8'h00;
            cnt_reg <= TPSRO_BITCNT_RST;
            ptr_reg <= TPSRO_PTR_RST;
            rd_addr_reg <= TPSRO_PTR_RST;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
            oe_reg <= 1'b0;
            id_meta_reg <= 4'h0;
            id_reg <= 4'h0;
        end
        else
        begin
            ist_reg <= ist_next;
            sh_reg <= sh_next;
            cnt_reg <= cnt_next;
            ptr_reg <= ptr_next;
            rd_addr_reg <= rd_addr_next;
            rw_reg <= rw_next;
            first_reg <= first_next;
            oe_reg <= oe_next;
            id_meta_reg <= bus_id;
            id_reg <= id_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Parameter snapshot and freeze control
    // ------------------------------------------------------------------
    logic idx_wr;
    assign idx_wr = wr_stb && wr_addr == TPSRO_OFS_INDEX &&
        wr_data < {4'h0, TPSRO_NUM_BYTES};

    always_comb
    begin
        snap_next = snap_reg;
        pend_next = pend_reg;
        frz_next = frz_reg;
        if (!frz_reg)
        begin
            if (tps_word_valid)
            begin
                snap_next[TPSRO_DATA_BITS-1:0] = tps_word;
                // Reserved span forced low whatever the decoder says
                snap_next[TPSRO_RSVD_HI:TPSRO_RSVD_LO] = '0;
            end
            snap_next[TPSRO_WORD_BITS-1:TPSRO_STAT_LSB] = lock_flags;
        end
        if (idx_wr)
        begin
            frz_next = 1'b1;
            pend_next = TPSRO_NUM_BYTES - wr_data[3:0];
        end
        else if (rd_done && frz_reg)
        begin
            pend_next = pend_reg - 4'h1;
            if (pend_reg == 4'h1)
                frz_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            snap_reg <= TPSRO_SNAP_RST;
            pend_reg <= TPSRO_PEND_RST;
            frz_reg <= 1'b0;
        end
        else
        begin
            snap_reg <= snap_next;
            pend_reg <= pend_next;
            frz_reg <= frz_next;
        end
    end

    // ------------------------------------------------------------------
    // Soft reset sequence
    // ------------------------------------------------------------------
    tpsro_srst_e sr_reg, sr_next;
    logic srp_reg, srp_next;
    logic sr_wr;
    assign sr_wr = wr_stb && wr_addr == TPSRO_OFS_SRST;

    // Pulse reaches only the loops; nothing here is cleared by it
    always_comb
    begin
        sr_next = sr_reg;
        srp_next = 1'b0;
        if (sr_wr)
        begin
            case (wr_data)
                8'h00:
                begin
                    srp_next = sr_reg == TPSRO_SR_GOT1;
                    sr_next = TPSRO_SR_GOT0;
                end
                8'h01:
                    sr_next = sr_reg == TPSRO_SR_GOT0 ? TPSRO_SR_GOT1 :
                        TPSRO_SR_IDLE;
                default:
                    sr_next = TPSRO_SR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            sr_reg <= TPSRO_SR_IDLE;
            srp_reg <= 1'b0;
        end
        else
        begin
            sr_reg <= sr_next;
            srp_reg <= srp_next;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = oe_reg;
    assign soft_rst_pulse = srp_reg;
    assign tps_frozen = frz_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_freeze_on_index: assert property (idx_wr |=> frz_reg)
        else $error("index write did not freeze");
    a_pending_count: assert property
        (idx_wr |=> pend_reg == TPSRO_NUM_BYTES - $past(wr_data[3:0]))
        else $error("pending count wrong");
    a_snap_held: assert property (frz_reg && $past(frz_reg) |->
        $stable(snap_reg))
        else $error("snapshot moved while frozen");
    a_refresh_live: assert property (!frz_reg && tps_word_valid |=>
        snap_reg[39:0] == $past(tps_word[39:0]))
        else $error("snapshot not refreshed");
    a_rsvd_zero: assert property (snap_reg[TPSRO_RSVD_HI:TPSRO_RSVD_LO]
        == '0)
        else $error("reserved bits not zero");
    a_status_map: assert property (!frz_reg |=>
        snap_reg[71:68] == $past(lock_flags))
        else $error("status bits misplaced");
    a_last_read: assert property (rd_done && frz_reg && pend_reg == 4'h1
        && !idx_wr |=> !frz_reg)
        else $error("refresh not resumed");
    a_read_counts: assert property (rd_done && frz_reg && pend_reg > 4'h1
        && !idx_wr |=> frz_reg && pend_reg == $past(pend_reg) - 4'h1)
        else $error("read not counted");
    a_srst_seq: assert property (srp_reg |-> $past(sr_wr) &&
        $past(wr_data) == 8'h00 && $past(sr_reg) == TPSRO_SR_GOT1)
        else $error("soft reset without 0-1-0");
    a_srst_single: assert property (srp_reg |=> !srp_reg ##1 !srp_reg)
        else $error("soft reset pulse too long");

    c_freeze: cover property (idx_wr ##1 frz_reg);
    c_unfreeze: cover property (frz_reg ##1 !frz_reg);
    c_soft_reset: cover property (srp_reg);
    c_read_ack: cover property (rd_done);

endmodule : tpsro_regs

// ==== tpsro_pkg.sv ====
// Constants, types and register map of the TPS capture and readout block.
// Assumes a single system clock domain; the host reaches it over a
// two-wire serial bus whose pins are sampled by that clock.
package tpsro_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] TPSRO_OFS_DATA_0 = 8'h00;
    localparam logic [7:0] TPSRO_OFS_DATA_4 = 8'h04;
    localparam logic [7:0] TPSRO_OFS_DATA_8 = 8'h08;
    localparam logic [7:0] TPSRO_OFS_INDEX = 8'h09;
    localparam logic [7:0] TPSRO_OFS_SRST = 8'h0A;

    // ------------------------------------------------------------------
    // Parameter word layout
    // ------------------------------------------------------------------
    localparam int TPSRO_WORD_BITS = 72;
    localparam int TPSRO_DATA_BITS = 68;
    localparam logic [3:0] TPSRO_NUM_BYTES = 4'h9;
    localparam int TPSRO_RSVD_LO = 40;
    localparam int TPSRO_RSVD_HI = 53;
    localparam int TPSRO_RSVD_W = TPSRO_RSVD_HI - TPSRO_RSVD_LO + 1;
    localparam int TPSRO_STAT_LSB = 68;

    // ------------------------------------------------------------------
    // Values after reset and bus constants
    // ------------------------------------------------------------------
    localparam logic [71:0] TPSRO_SNAP_RST = 72'h0;
    localparam logic [3:0] TPSRO_PEND_RST = 4'h0;
    localparam logic [7:0] TPSRO_PTR_RST = 8'h00;
    localparam logic [3:0] TPSRO_BITCNT_RST = 4'h0;
    localparam logic [3:0] TPSRO_BYTE_BITS = 4'h8;
    localparam logic [2:0] TPSRO_ADDR_HI_DEF = 3'b010;

    // Lock flags, packed so the vector drops straight into bits 71..68
    typedef struct packed {
        logic afc_lock;
        logic clk_lock;
        logic tps_valid;
        logic tps_lock;
    } tpsro_lock_s;

    typedef enum logic [2:0] {
        TPSRO_I_IDLE = 3'b000,
        TPSRO_I_ADDR = 3'b001,
        TPSRO_I_ACK_A = 3'b010,
        TPSRO_I_WR = 3'b011,
        TPSRO_I_ACK_W = 3'b100,
        TPSRO_I_RD = 3'b101,
        TPSRO_I_ACK_R = 3'b110
    } tpsro_i2c_e;

    typedef enum logic [1:0] {
        TPSRO_SR_IDLE = 2'b00,
        TPSRO_SR_GOT0 = 2'b01,
        TPSRO_SR_GOT1 = 2'b10
    } tpsro_srst_e;

endpackage : tpsro_pkg

// ==== tpsro_pin_sync.sv ====
// Pin synchroniser and bus event finder for the serial clock and data.
// Assumes raw pin levels from outside the clk_sys domain.
`timescale 1ns/100ps
module tpsro_pin_sync
(
    input wire logic clk_sys, // System clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic scl_in, // Raw serial clock pin
    input wire logic sda_in, // Raw serial data pin
    output logic sda_lvl, // Synchronised data level
    output logic scl_rise, // Serial clock rose
    output logic scl_fall, // Serial clock fell
    output logic bus_start, // Start condition seen
    output logic bus_stop // Stop condition seen
);
    import tpsro_pkg::*;

    logic [1:0] scl_meta_reg, scl_meta_next;
    logic [1:0] sda_meta_reg, sda_meta_next;
    logic scl_old_reg, scl_old_next;
    logic sda_old_reg, sda_old_next;

    // ------------------------------------------------------------------
    // Two-flop synchronisers; only stage 2 and the history are looked at
    // ------------------------------------------------------------------
    always_comb
    begin
        scl_meta_next = {scl_meta_reg[0], scl_in};
        sda_meta_next = {sda_meta_reg[0], sda_in};
        scl_old_next = scl_meta_reg[1];
        sda_old_next = sda_meta_reg[1];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            scl_meta_reg <= 2'b11;
            sda_meta_reg <= 2'b11;
            scl_old_reg <= 1'b1;
            sda_old_reg <= 1'b1;
        end
        else
        begin
            scl_meta_reg <= scl_meta_next;
            sda_meta_reg <= sda_meta_next;
            scl_old_reg <= scl_old_next;
            sda_old_reg <= sda_old_next;
        end
    end

    assign sda_lvl = sda_meta_reg[1];
    assign scl_rise = scl_meta_reg[1] & ~scl_old_reg;
    assign scl_fall = ~scl_meta_reg[1] & scl_old_reg;
    assign bus_start = scl_meta_reg[1] & scl_old_reg & ~sda_meta_reg[1] &
        sda_old_reg;
    assign bus_stop = scl_meta_reg[1] & scl_old_reg & sda_meta_reg[1] &
        ~sda_old_reg;

endmodule : tpsro_pin_sync

// ==== tpsro_host_model.sv ====
// Behavioural serial-bus master that reaches the TPS readout registers.
// Assumes an open-drain data wire with a pull-up, resolved by the bench.
`timescale 1ns/100ps
module tpsro_host_model
(
    input wire logic [6:0] dev_addr, // Slave address to call
    input wire logic sda_line, // Resolved data wire level
    output logic scl, // Serial clock, stands high outside frames
    output logic sda_pull // High while the host pulls data low
);
    // ------------------------------------------------------------------
    // Bit level, 64 ns serial clock period
    // ------------------------------------------------------------------
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Data moves 16 ns after the clock falls, off the sampling clock edge
    task automatic put_bit(input logic b);
        scl = 1'b0;
        #16 sda_pull = ~b;
        #16 scl = 1'b1;
        #32;
    endtask : put_bit

    task automatic get_bit(output logic b);
        scl = 1'b0;
        #16 sda_pull = 1'b0;
        #16 scl = 1'b1;
        #16 b = sda_line;
        #16;
    endtask : get_bit

    // Works from idle and as a repeated start after an acknowledge slot
    task automatic bus_start;
        scl = 1'b0;
        #16 sda_pull = 1'b0;
        #16 scl = 1'b1;
        #32 sda_pull = 1'b1;
        #32;
    endtask : bus_start

    task automatic bus_stop;
        scl = 1'b0;
        #16 sda_pull = 1'b1;
        #16 scl = 1'b1;
        #32 sda_pull = 1'b0;
        #32;
    endtask : bus_stop

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i]);
        get_bit(b);
        ack = ~b;
    endtask : put_byte

    // ------------------------------------------------------------------
    // Register accesses
    // ------------------------------------------------------------------
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d,
                             output logic ok);
        logic k1, k2, k3;
        bus_start();
        put_byte({dev_addr, 1'b0}, k1);
        put_byte(a, k2);
        put_byte(d, k3);
        bus_stop();
        ok = k1 & k2 & k3;
    endtask : reg_write

    // One byte per access, ended by a NACK, so each call is one read
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d,
                            output logic ok);
        logic k1, k2, k3;
        bus_start();
        put_byte({dev_addr, 1'b0}, k1);
        put_byte(a, k2);
        bus_start();
        put_byte({dev_addr, 1'b1}, k3);
        for (int i = 7; i >= 0; i--)
            get_bit(d[i]);
        put_bit(1'b1);
        bus_stop();
        ok = k1 & k2 & k3;
    endtask : reg_read
endmodule : tpsro_host_model

// ==== tpsro_regs_tb_top.sv ====
// Self-checking bench for the TPS capture and readout registers.
// Assumes the host model above on the serial pins and a 125 MHz clk_sys.
`timescale 1ns/100ps
module tpsro_regs_tb_top;
    import tpsro_pkg::*;
    logic clk_sys, nrst, scl, sda_pull, sda_line, sda_out, sda_oe;
    logic [3:0] bus_id;
    logic [6:0] host_addr;
    logic [67:0] tps_word;
    logic tps_word_valid, soft_rst_pulse, tps_frozen, ok;
    tpsro_lock_s lock_flags;
    logic [31:0] rng;
    logic [71:0] exp_snap, held;
    logic [7:0] d;
    int errors, check_count, pulse_cnt, p0, a;

    assign sda_line = sda_oe ? sda_out : ~sda_pull;

    tpsro_regs tpsro_regs_i (.clk_sys(clk_sys), .nrst(nrst), .bus_id(bus_id),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .tps_word(tps_word), .tps_word_valid(tps_word_valid),
        .lock_flags(lock_flags), .soft_rst_pulse(soft_rst_pulse),
        .tps_frozen(tps_frozen));
    tpsro_host_model tpsro_host_model_i (.dev_addr(host_addr),
        .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    always @(negedge clk_sys)
        if (soft_rst_pulse === 1'b1)
            pulse_cnt++;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs_next(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xs_next

    // Reserved field reads zero whatever the decoder hands over
    function automatic logic [71:0] snap_of(input logic [67:0] w,
                                            input tpsro_lock_s lk);
        logic [71:0] s;
        s = {lk, w};
        s[TPSRO_RSVD_HI:TPSRO_RSVD_LO] = '0;
        return s;
    endfunction : snap_of

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic new_live;
        @(negedge clk_sys);
        for (int i = 0; i < 3; i++)
        begin
            rng = xs_next(rng);
            tps_word = {tps_word[35:0], rng};
        end
        lock_flags = tpsro_lock_s'(rng[7:4]);
        tps_word_valid = 1'b1;
        @(negedge clk_sys);
        tps_word_valid = 1'b0;
        exp_snap = snap_of(tps_word, lock_flags);
        repeat (4) @(negedge clk_sys);
    endtask : new_live

    task automatic srst_seq(input logic [7:0] b0, input logic [7:0] b1,
                            input logic [7:0] b2);
        tpsro_host_model_i.reg_write(TPSRO_OFS_SRST, b0, ok);
        tpsro_host_model_i.reg_write(TPSRO_OFS_SRST, b1, ok);
        tpsro_host_model_i.reg_write(TPSRO_OFS_SRST, b2, ok);
        repeat (4) @(negedge clk_sys);
    endtask : srst_seq

    task automatic end_sim;
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        rng = 32'h25;
        rng = xs_next(rng);
        bus_id = rng[3:0];
        host_addr = {TPSRO_ADDR_HI_DEF, bus_id};
        nrst = 1'b0;
        tps_word = '0;
        tps_word_valid = 1'b0;
        lock_flags = '0;
        repeat (16) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk_bit(tps_frozen, 1'b0);
        chk_bit(sda_oe, 1'b0);
        $display("test reset done");
        // Every index value, boundary 0 and 8 included
        for (int x = 0; x <= 8; x++)
        begin
            new_live();
            held = exp_snap;
            tpsro_host_model_i.reg_write(TPSRO_OFS_INDEX, 8'(x), ok);
            chk_bit(ok, 1'b1);
            chk_bit(tps_frozen, 1'b1);
            new_live();
            for (int k = 0; k < 9 - x; k++)
            begin
                chk_bit(tps_frozen, 1'b1);
                a = (k * 5 + x) % 9;
                tpsro_host_model_i.reg_read(8'(a), d, ok);
                chk_byte(d, held[8 * a +: 8]);
            end
            repeat (2) @(negedge clk_sys);
            chk_bit(tps_frozen, 1'b0);
            new_live();
            tpsro_host_model_i.reg_read(TPSRO_OFS_DATA_8, d, ok);
            chk_byte(d, exp_snap[71:64]);
            tpsro_host_model_i.reg_read(TPSRO_OFS_DATA_4, d, ok);
            chk_byte(d, exp_snap[39:32]);
        end
        $display("test freeze_read done");
        tpsro_host_model_i.reg_write(TPSRO_OFS_INDEX, 8'h09, ok);
        chk_bit(tps_frozen, 1'b0);
        tpsro_host_model_i.reg_read(8'h0B, d, ok);
        chk_byte(d, 8'h00);
        tpsro_host_model_i.reg_write(TPSRO_OFS_DATA_4, 8'h00, ok);
        chk_bit(tps_frozen, 1'b0);
        host_addr = {TPSRO_ADDR_HI_DEF, ~bus_id};
        tpsro_host_model_i.reg_write(TPSRO_OFS_INDEX, 8'h00, ok);
        chk_bit(ok, 1'b0);
        chk_bit(tps_frozen, 1'b0);
        host_addr = {TPSRO_ADDR_HI_DEF, bus_id};
        $display("test refusals done");
        p0 = pulse_cnt;
        srst_seq(8'h00, 8'h02, 8'h00);
        chk_byte(8'(pulse_cnt - p0), 8'h00);
        held = exp_snap;
        tpsro_host_model_i.reg_write(TPSRO_OFS_INDEX, 8'h07, ok);
        srst_seq(8'h00, 8'h01, 8'h00);
        chk_byte(8'(pulse_cnt - p0), 8'h01);
        chk_bit(tps_frozen, 1'b1);
        tpsro_host_model_i.reg_read(TPSRO_OFS_DATA_0, d, ok);
        chk_byte(d, held[7:0]);
        chk_bit(tps_frozen, 1'b1);
        tpsro_host_model_i.reg_read(8'h02, d, ok);
        chk_byte(d, held[23:16]);
        repeat (2) @(negedge clk_sys);
        chk_bit(tps_frozen, 1'b0);
        $display("test soft_reset done");
        end_sim();
    end

    initial
    begin
        #400000;
        errors++;
        end_sim();
    end
endmodule : tpsro_regs_tb_top
